//--- hw/rtcsf_cfg.svh
// register map, field positions, reset values and timing counts of the rtc trim and unlock control
// Operation
// [RULE_01] test wave off: pin shows level bit
// [RULE_02] test wave on: pin shows square wave
// [RULE_03] protected rate bit picks wave frequency
// [RULE_04] trim direction: 0 slows, 1 speeds
// [RULE_05] slow N/491520, speed N/245760 per minute
// [RULE_06] trim magnitude spans 0 to 31
// [RULE_07] host writes reserved bits as zero
// [RULE_08] first key 0x5E, reads 0x00
// [RULE_09] second key 0xC7, reads 0x00
// [RULE_10] protected write needs keys in order
// [RULE_11] host sends both keys before each write
// [RULE_12] rate bit clear gives 512 Hz
// [RULE_13] 512 Hz wave ignores trim
// [RULE_14] rate bit set gives trimmed 1 Hz
// [RULE_15] year divisible by four is leap
// [RULE_16] backup supply: bus stops, time continues
// [RULE_17] host waits one second after backup
// [RULE_18] unkeyed protected writes ignored, keys repeat
`ifndef RTCSF_CFG_SVH
`define RTCSF_CFG_SVH

`define RTCSF_ADDR_W          8
`define RTCSF_OFS_CAL         8'h07
`define RTCSF_OFS_SCFG        8'h09
`define RTCSF_OFS_KEY1        8'h20
`define RTCSF_OFS_KEY2        8'h21
`define RTCSF_OFS_PFUNC       8'h22

`define RTCSF_RST_CAL         8'h80
`define RTCSF_RST_SCFG        8'hAA
`define RTCSF_RST_PFUNC       8'h00
`define RTCSF_KEY1_VAL        8'h5E
`define RTCSF_KEY2_VAL        8'hC7
`define RTCSF_KEY_READ        8'h00
`define RTCSF_UNMAPPED_READ   8'h00

`define RTCSF_BIT_RATE        0

`define RTCSF_OSC_HZ          32768
`define RTCSF_TEST_HZ         512
`define RTCSF_SEC_PER_MIN     60
`define RTCSF_SLOW_DIV        491520
`define RTCSF_FAST_DIV        245760

`endif

//--- hw/rtcsf_pkg.sv
// types shared by the rtc trim and unlock control
package rtcsf_pkg;

	// one register access from the serial framing logic
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rtcsf_req_s;

	// calibration and control byte
	typedef struct packed {
		logic       level;
		logic       wave_en;
		logic       speed;
		logic [4:0] mag;
	} rtcsf_cal_s;

	typedef enum logic [1:0] {
		RTCSF_LOCKED,
		RTCSF_KEY1_SEEN,
		RTCSF_UNLOCKED
	} rtcsf_key_e;

endpackage

//--- hw/rtcsf_trim_div.sv
// oscillator tick divider: untrimmed 512 Hz wave, trimmed 1 Hz wave and second tick
`timescale 1ns/1ps
`include "rtcsf_cfg.svh"
`default_nettype none
module rtcsf_trim_div #(
	parameter int TICKS_PER_SEC = `RTCSF_OSC_HZ
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       osc_tick,
	input  wire logic       trim_speed,
	input  wire logic [4:0] trim_mag,
	output logic            wave_512_q,
	output logic            wave_1hz_q,
	output logic            sec_tick_q
);
	localparam int HALF_512 = `RTCSF_OSC_HZ / (2 * `RTCSF_TEST_HZ);
	localparam int MIN_TICKS = `RTCSF_OSC_HZ * `RTCSF_SEC_PER_MIN;
	localparam int SLOW_MUL = MIN_TICKS / `RTCSF_SLOW_DIV;
	localparam int FAST_MUL = MIN_TICKS / `RTCSF_FAST_DIV;
	localparam logic [16:0] TPS = 17'(TICKS_PER_SEC);

	logic [5:0]  pre_q, pre_d;
	logic        w512_d;
	logic [16:0] sub_q, sub_d;
	logic [5:0]  min_q, min_d;
	logic [7:0]  corr_q, corr_d;
	logic        w1_d, sec_d;
	logic [16:0] sum;
	logic [1:0]  step;

	// untrimmed prescaler straight from the oscillator ticks
	always_comb begin
		pre_d = pre_q;
		w512_d = wave_512_q;
		if (osc_tick) begin
			if (pre_q == 6'(HALF_512 - 1)) begin
				pre_d = '0;
				w512_d = ~wave_512_q; // RULE_13
			end else begin
				pre_d = pre_q + 6'h01;
			end
		end
	end

	// trimmed second counter; correction ticks are swallowed or doubled once a minute
	always_comb begin
		step = 2'h1;
		if (corr_q != 8'h00) begin
			step = trim_speed ? 2'h2 : 2'h0; // RULE_04
		end
		sum = sub_q + 17'(step);
		sub_d = sub_q;
		min_d = min_q;
		corr_d = corr_q;
		sec_d = 1'b0;
		if (osc_tick) begin
			if (corr_q != 8'h00) begin
				corr_d = corr_q - 8'h01;
			end
			if (sum >= TPS) begin
				sub_d = sum - TPS;
				sec_d = 1'b1;
				if (min_q == 6'(`RTCSF_SEC_PER_MIN - 1)) begin
					min_d = '0;
					// RULE_05 RULE_06
					corr_d = trim_speed ? 8'(FAST_MUL * trim_mag) : 8'(SLOW_MUL * trim_mag);
				end else begin
					min_d = min_q + 6'h01;
				end
			end else begin
				sub_d = sum;
			end
		end
		w1_d = (sub_d < (TPS >> 1)); // RULE_14
	end

	// register the divider state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pre_q <= '0;
			wave_512_q <= 1'b0;
			sub_q <= '0;
			min_q <= '0;
			corr_q <= '0;
			wave_1hz_q <= 1'b0;
			sec_tick_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			wave_512_q <= w512_d;
			sub_q <= sub_d;
			min_q <= min_d;
			corr_q <= corr_d;
			wave_1hz_q <= w1_d;
			sec_tick_q <= sec_d;
		end
	end

	property p_corr_load;
		@(posedge clk_sys) disable iff (rst)
		(osc_tick && sum >= TPS && min_q == 6'(`RTCSF_SEC_PER_MIN - 1))
			|=> corr_q == ($past(trim_speed) ? 8'(8 * $past(trim_mag)) : 8'(4 * $past(trim_mag)));
	endproperty
	a_corr_load: assert property (p_corr_load) else $error("trim amount not loaded"); // RULE_05

	property p_slow_hold;
		@(posedge clk_sys) disable iff (rst)
		(osc_tick && corr_q != 8'h00 && !trim_speed) |=> sub_q == $past(sub_q);
	endproperty
	a_slow_hold: assert property (p_slow_hold) else $error("slow trim tick not swallowed"); // RULE_04

	property p_512_free;
		@(posedge clk_sys) disable iff (rst)
		(!osc_tick) |=> $stable(wave_512_q);
	endproperty
	a_512_free: assert property (p_512_free) else $error("512 Hz wave moved without a tick"); // RULE_13
endmodule // rtcsf_trim_div
`default_nettype wire

//--- hw/rtcsf_ctrl.sv
// rtc trim, test output and key-protected function control, top level
`timescale 1ns/1ps
`include "rtcsf_cfg.svh"
`default_nettype none
module rtcsf_ctrl #(
	parameter int TICKS_PER_SEC = `RTCSF_OSC_HZ
) (
	input  wire logic                clk_sys,
	input  wire logic                rst,
	input  wire logic                osc_clk_i,
	input  wire logic                backup_pin_i,
	input  wire rtcsf_pkg::rtcsf_req_s req,
	input  wire logic [7:0]          year_bcd,
	output logic [7:0]               rd_data_q,
	output logic                     rd_valid_q,
	output logic                     irq_level_q,
	output logic                     sec_tick_q,
	output logic                     leap_year_q
);
	logic                  osc_s1_q, osc_s2_q, osc_s3_q;
	logic                  bk_s1_q, bk_s2_q;
	logic                  osc_tick;
	logic                  wave_512, wave_1hz;
	rtcsf_pkg::rtcsf_cal_s cal_q, cal_d;
	logic [7:0]            scfg_q, scfg_d;
	logic [7:0]            pfunc_q, pfunc_d;
	rtcsf_pkg::rtcsf_key_e key_q, key_d;
	logic [7:0]            rdata_d;
	logic                  rvalid_d;
	logic                  irq_d;
	logic                  leap_d;
	logic                  wr_ok, rd_ok;

	// pin synchronisers; only the second stage onward is looked at
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			osc_s1_q <= 1'b0;
			osc_s2_q <= 1'b0;
			osc_s3_q <= 1'b0;
			bk_s1_q <= 1'b0;
			bk_s2_q <= 1'b0;
		end else begin
			osc_s1_q <= osc_clk_i;
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
			bk_s1_q <= backup_pin_i;
			bk_s2_q <= bk_s1_q;
		end
	end

	assign osc_tick = osc_s2_q & ~osc_s3_q; // rising oscillator edge

	// timekeeping keeps running whatever the supply state
	rtcsf_trim_div #(
		.TICKS_PER_SEC (TICKS_PER_SEC)
	) u_div (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.osc_tick   (osc_tick),
		.trim_speed (cal_q.speed),
		.trim_mag   (cal_q.mag),
		.wave_512_q (wave_512),
		.wave_1hz_q (wave_1hz),
		.sec_tick_q (sec_tick_q)
	);

	// bus accesses are dropped while on backup supply
	assign wr_ok = req.wr & ~bk_s2_q; // RULE_16
	assign rd_ok = req.rd & ~bk_s2_q; // RULE_16

	// register writes and the key sequencer
	always_comb begin
		cal_d = cal_q;
		scfg_d = scfg_q;
		pfunc_d = pfunc_q;
		key_d = key_q;
		if (wr_ok) begin
			key_d = rtcsf_pkg::RTCSF_LOCKED; // any other write breaks the sequence
			unique case (req.addr)
				`RTCSF_OFS_CAL: begin
					cal_d = req.wdata;
				end
				`RTCSF_OFS_SCFG: begin
					scfg_d = req.wdata;
				end
				`RTCSF_OFS_KEY1: begin
					if (req.wdata == `RTCSF_KEY1_VAL) begin
						key_d = rtcsf_pkg::RTCSF_KEY1_SEEN; // RULE_08
					end
				end
				`RTCSF_OFS_KEY2: begin
					if (key_q == rtcsf_pkg::RTCSF_KEY1_SEEN && req.wdata == `RTCSF_KEY2_VAL) begin
						key_d = rtcsf_pkg::RTCSF_UNLOCKED; // RULE_09 RULE_10
					end
				end
				`RTCSF_OFS_PFUNC: begin
					if (key_q == rtcsf_pkg::RTCSF_UNLOCKED) begin
						pfunc_d = req.wdata; // RULE_10 RULE_18
					end
				end
				default: begin
				end
			endcase
		end
	end

	// read data; key registers and holes read as zero
	always_comb begin
		rdata_d = rd_data_q;
		rvalid_d = rd_ok;
		if (rd_ok) begin
			unique case (req.addr)
				`RTCSF_OFS_CAL: rdata_d = cal_q;
				`RTCSF_OFS_SCFG: rdata_d = scfg_q;
				`RTCSF_OFS_KEY1: rdata_d = `RTCSF_KEY_READ; // RULE_08
				`RTCSF_OFS_KEY2: rdata_d = `RTCSF_KEY_READ; // RULE_09
				`RTCSF_OFS_PFUNC: rdata_d = pfunc_q;
				default: rdata_d = `RTCSF_UNMAPPED_READ;
			endcase
		end
	end

	// pin level: static level, or a test wave at the selected rate
	always_comb begin
		if (cal_q.wave_en) begin
			// RULE_02 RULE_03 RULE_12 RULE_14
			irq_d = pfunc_q[`RTCSF_BIT_RATE] ? wave_1hz : wave_512;
		end else begin
			irq_d = cal_q.level; // RULE_01
		end
	end

	// bcd year divisible by four: even tens with 0/4/8, odd tens with 2/6
	always_comb begin
		if (year_bcd[4]) begin
			leap_d = (year_bcd[3:0] == 4'h2) || (year_bcd[3:0] == 4'h6); // RULE_15
		end else begin
			leap_d = (year_bcd[3:0] == 4'h0) || (year_bcd[3:0] == 4'h4) ||
				(year_bcd[3:0] == 4'h8); // RULE_15
		end
	end

	// register all control state and the read, pin and leap outputs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cal_q <= `RTCSF_RST_CAL;
			scfg_q <= `RTCSF_RST_SCFG;
			pfunc_q <= `RTCSF_RST_PFUNC;
			key_q <= rtcsf_pkg::RTCSF_LOCKED;
			rd_data_q <= 8'h00;
			rd_valid_q <= 1'b0;
			irq_level_q <= 1'b1;
			leap_year_q <= 1'b0;
		end else begin
			cal_q <= cal_d;
			scfg_q <= scfg_d;
			pfunc_q <= pfunc_d;
			key_q <= key_d;
			rd_data_q <= rdata_d;
			rd_valid_q <= rvalid_d;
			irq_level_q <= irq_d;
			leap_year_q <= leap_d;
		end
	end

	sequence s_key1;
		wr_ok && req.addr == `RTCSF_OFS_KEY1 && req.wdata == `RTCSF_KEY1_VAL;
	endsequence

	sequence s_key2;
		wr_ok && req.addr == `RTCSF_OFS_KEY2 && req.wdata == `RTCSF_KEY2_VAL;
	endsequence

	sequence s_pfunc_wr;
		wr_ok && req.addr == `RTCSF_OFS_PFUNC;
	endsequence

	property p_static_level;
		@(posedge clk_sys) disable iff (rst)
		!cal_q.wave_en |=> irq_level_q == $past(cal_q.level);
	endproperty
	a_static_level: assert property (p_static_level) else $error("pin not at static level"); // RULE_01

	property p_wave_out;
		@(posedge clk_sys) disable iff (rst)
		cal_q.wave_en |=> irq_level_q == ($past(pfunc_q[0]) ? $past(wave_1hz) : $past(wave_512));
	endproperty
	a_wave_out: assert property (p_wave_out) else $error("pin not at selected test wave"); // RULE_03

	property p_key1_read;
		@(posedge clk_sys) disable iff (rst)
		rd_ok && req.addr == `RTCSF_OFS_KEY1 |=> rd_valid_q && rd_data_q == 8'h00;
	endproperty
	a_key1_read: assert property (p_key1_read) else $error("first key reads nonzero"); // RULE_08

	property p_key2_read;
		@(posedge clk_sys) disable iff (rst)
		rd_ok && req.addr == `RTCSF_OFS_KEY2 |=> rd_valid_q && rd_data_q == 8'h00;
	endproperty
	a_key2_read: assert property (p_key2_read) else $error("second key reads nonzero"); // RULE_09

	property p_keyed_write;
		@(posedge clk_sys) disable iff (rst)
		s_key1 ##1 s_key2 ##1 s_pfunc_wr |=> pfunc_q == $past(req.wdata);
	endproperty
	a_keyed_write: assert property (p_keyed_write) else $error("keyed write not taken"); // RULE_10

	property p_unkeyed_write;
		@(posedge clk_sys) disable iff (rst)
		s_pfunc_wr and (key_q != rtcsf_pkg::RTCSF_UNLOCKED) |=> $stable(pfunc_q);
	endproperty
	a_unkeyed_write: assert property (p_unkeyed_write) else $error("unkeyed write taken"); // RULE_18

	property p_relock;
		@(posedge clk_sys) disable iff (rst)
		s_pfunc_wr |=> key_q == rtcsf_pkg::RTCSF_LOCKED ##1 1'b1;
	endproperty
	a_relock: assert property (p_relock) else $error("lock not restored after write"); // RULE_18

	property p_backup_block;
		@(posedge clk_sys) disable iff (rst)
		bk_s2_q |=> $stable(cal_q) && $stable(scfg_q) && $stable(pfunc_q) && !rd_valid_q;
	endproperty
	a_backup_block: assert property (p_backup_block) else $error("bus acted on backup"); // RULE_16

	property p_odd_year;
		@(posedge clk_sys) disable iff (rst)
		year_bcd[0] |=> !leap_year_q;
	endproperty
	a_odd_year: assert property (p_odd_year) else $error("odd year flagged leap"); // RULE_15
endmodule // rtcsf_ctrl
`default_nettype wire

//--- dv/rtcsf_host.sv
// host model: register writes, reads and keyed protected writes
`timescale 1ns/1ps
`default_nettype none
`include "rtcsf_cfg.svh"
module rtcsf_host (
	input  wire logic                  clk_sys,
	input  wire logic                  rd_valid_q,
	input  wire logic [7:0]            rd_data_q,
	output var  rtcsf_pkg::rtcsf_req_s req
);
	initial req = '0;

	// one write pulse, launched and released off falling edges
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		req <= '{1'b1, 1'b0, a, d};
		@(negedge clk_sys);
		req <= '0;
	endtask

	// one read pulse; ok stays low when no answer comes in time
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		int i;
		@(negedge clk_sys);
		req <= '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk_sys);
		req <= '0;
		ok = 1'b0;
		d = 8'h00;
		for (i = 0; i < 4 && !ok; i++) begin
			if (rd_valid_q === 1'b1) begin
				ok = 1'b1;
				d = rd_data_q;
			end else
				@(negedge clk_sys);
		end
	endtask

	// both keys go ahead of every protected write, back to back, spare bits sent as zero
	task automatic wr_prot(input logic [7:0] d);
		@(negedge clk_sys);
		req <= '{1'b1, 1'b0, `RTCSF_OFS_KEY1, `RTCSF_KEY1_VAL};
		@(negedge clk_sys);
		req <= '{1'b1, 1'b0, `RTCSF_OFS_KEY2, `RTCSF_KEY2_VAL};
		@(negedge clk_sys);
		req <= '{1'b1, 1'b0, `RTCSF_OFS_PFUNC, d & (8'h01 << `RTCSF_BIT_RATE)};
		@(negedge clk_sys);
		req <= '0;
	endtask
endmodule // rtcsf_host
`default_nettype wire

//--- dv/testbench.sv
// self-checking testbench of the rtc trim and unlock control
`timescale 1ns/1ps
`default_nettype none
`include "rtcsf_cfg.svh"
module testbench;
	localparam int TPS = 96;
	logic                  clk_sys;
	logic                  rst;
	logic                  osc_clk_i;
	logic                  backup_pin_i;
	rtcsf_pkg::rtcsf_req_s req;
	logic [7:0]            year_bcd;
	logic [7:0]            rd_data_q;
	logic                  rd_valid_q;
	logic                  irq_level_q;
	logic                  sec_tick_q;
	logic                  leap_year_q;
	int                    fails;
	int                    n_tests;
	int                    c;
	int                    n;
	int                    i;
	logic [7:0]            d;
	logic [7:0]            d2;
	logic                  ok;
	logic [7:0]            ra[6] = '{8'h07, 8'h09, 8'h22, 8'h20, 8'h21, 8'h3F};
	logic [7:0]            rv[6] = '{`RTCSF_RST_CAL, `RTCSF_RST_SCFG, `RTCSF_RST_PFUNC,
		`RTCSF_KEY_READ, `RTCSF_KEY_READ, `RTCSF_UNMAPPED_READ};

	rtcsf_ctrl #(.TICKS_PER_SEC(TPS)) dut_u (.clk_sys(clk_sys), .rst(rst),
		.osc_clk_i(osc_clk_i), .backup_pin_i(backup_pin_i), .req(req),
		.year_bcd(year_bcd), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
		.irq_level_q(irq_level_q), .sec_tick_q(sec_tick_q), .leap_year_q(leap_year_q));
	rtcsf_host host_u (.clk_sys(clk_sys), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
		.req(req));

	// system clock and free-running oscillator
	initial clk_sys = 1'b0;
	always #4 clk_sys = ~clk_sys;
	initial osc_clk_i = 1'b0;
	always #40 osc_clk_i = ~osc_clk_i;

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	task automatic tmo;
		fails++;
		$display("CHECK FAILED wait_bound expected event seen none");
		print_verdict();
	endtask

	// cycles from one pin change to the next
	task automatic gap(output int cnt);
		logic v;
		int k;
		v = irq_level_q;
		k = 0;
		while (irq_level_q === v && k < 2000) begin
			@(negedge clk_sys);
			k++;
		end
		v = irq_level_q;
		cnt = 0;
		while (irq_level_q === v && cnt < 2000) begin
			@(negedge clk_sys);
			cnt++;
		end
		if (cnt >= 2000)
			tmo();
	endtask

	// cycles up to the next second pulse
	task automatic tick_wait(output int cnt);
		cnt = 0;
		do begin
			@(negedge clk_sys);
			cnt++;
		end while (sec_tick_q !== 1'b1 && cnt < 5000);
		if (cnt >= 5000)
			tmo();
	endtask

	function automatic logic leap_of(input logic [7:0] y);
		return ((int'(y[7:4]) * 10 + int'(y[3:0])) % 4) == 0;
	endfunction

	// main sequence
	initial begin
		rst = 1'b1;
		backup_pin_i = 1'b0;
		year_bcd = 8'h00;
		fails = 0;
		n_tests = 0;
		void'($urandom(82200));
		repeat (10) @(negedge clk_sys);
		rst = 1'b0;
		chk("irq_reset", 1, irq_level_q);
		for (i = 0; i < 6; i++) begin
			host_u.rd(ra[i], d2, ok);
			chk("reset_read", {1'b1, rv[i]}, {ok, d2});
		end
		repeat (8) begin
			d = 8'($urandom) & 8'hBF;
			host_u.wr(`RTCSF_OFS_CAL, d);
			repeat (2) @(negedge clk_sys);
			chk("irq_level", d[7], irq_level_q);
			host_u.rd(`RTCSF_OFS_CAL, d2, ok);
			chk("cal_read", {1'b1, d}, {ok, d2});
		end
		host_u.wr(`RTCSF_OFS_SCFG, 8'h00);
		host_u.rd(`RTCSF_OFS_SCFG, d2, ok);
		chk("scfg_read", {1'b1, 8'h00}, {ok, d2});
		// unkeyed, misordered, broken and wrong key sequences
		host_u.wr(`RTCSF_OFS_PFUNC, 8'h01);
		host_u.wr(`RTCSF_OFS_KEY2, `RTCSF_KEY2_VAL);
		host_u.wr(`RTCSF_OFS_KEY1, `RTCSF_KEY1_VAL);
		host_u.wr(`RTCSF_OFS_PFUNC, 8'h01);
		host_u.wr(`RTCSF_OFS_KEY1, `RTCSF_KEY1_VAL);
		host_u.wr(`RTCSF_OFS_SCFG, 8'h00);
		host_u.wr(`RTCSF_OFS_KEY2, `RTCSF_KEY2_VAL);
		host_u.wr(`RTCSF_OFS_PFUNC, 8'h01);
		host_u.wr(`RTCSF_OFS_KEY1, 8'h5F);
		host_u.wr(`RTCSF_OFS_KEY2, `RTCSF_KEY2_VAL);
		host_u.wr(`RTCSF_OFS_PFUNC, 8'h01);
		host_u.wr(`RTCSF_OFS_KEY1, `RTCSF_KEY1_VAL);
		host_u.wr(`RTCSF_OFS_KEY2, 8'hC6);
		host_u.wr(`RTCSF_OFS_PFUNC, 8'h01);
		host_u.rd(`RTCSF_OFS_PFUNC, d2, ok);
		chk("pfunc_locked", {1'b1, 8'h00}, {ok, d2});
		host_u.wr_prot(8'h01);
		host_u.wr(`RTCSF_OFS_PFUNC, 8'h00);
		host_u.rd(`RTCSF_OFS_PFUNC, d2, ok);
		chk("pfunc_keyed", 8'h01, d2);
		// trimmed 1 Hz wave with no trim, then untrimmed 512 Hz under full speed trim
		host_u.wr(`RTCSF_OFS_CAL, 8'h40);
		gap(c);
		gap(c);
		chk("wave_1hz_half", TPS / 2 * 10, c);
		host_u.wr_prot(8'h00);
		host_u.wr(`RTCSF_OFS_CAL, 8'h7F);
		gap(c);
		gap(c);
		chk("wave_512_half", `RTCSF_OSC_HZ / `RTCSF_TEST_HZ / 2 * 10, c);
		// skip eight seconds so the window holds the end of the first minute and one whole trim burst
		repeat (8) tick_wait(c);
		n = 0;
		repeat (60) begin
			tick_wait(c);
			n += c;
		end
		c = (60 * TPS - 8 * 31) * 10;
		chk("minute_cycles", 1, n >= c - 20 && n <= c + 20);
		// backup supply: bus refused while seconds go on
		backup_pin_i = 1'b1;
		repeat (4) @(negedge clk_sys);
		host_u.wr(`RTCSF_OFS_CAL, 8'h80);
		host_u.rd(`RTCSF_OFS_CAL, d2, ok);
		chk("backup_refused", 0, ok);
		tick_wait(c);
		chk("backup_tick", 1, c < 5000);
		backup_pin_i = 1'b0;
		repeat (TPS * 10) @(negedge clk_sys);
		host_u.rd(`RTCSF_OFS_CAL, d2, ok);
		chk("cal_kept", 8'h7F, d2);
		for (i = 0; i < 12; i++) begin
			year_bcd = (i == 0) ? 8'h00 : {4'($urandom % 10), 4'($urandom % 10)};
			repeat (2) @(negedge clk_sys);
			chk("leap_year", leap_of(year_bcd), leap_year_q);
		end
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
